// ### ddr_link_assertions.sv
// Purpose: link checks between the sram device and its controller
// Assumes: k and k_n are clk flops, so clk sees every link edge
// Notes:   one clk domain; link half period is two clk cycles
`timescale 1ns/100ps
`default_nettype none
module ddr_link_assertions
  import ddr_sram_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       k,
  input wire logic       k_n,
  input wire logic       cmd_valid,
  input wire logic       cmd_write,
  input wire logic       ctl_dq_oe_n,
  input wire logic       dev_dq_oe_n,
  input wire logic [1:0] echo_clock_pair,
  input wire logic       read_valid_flag,
  input wire logic       pll_off_select
);
  logic k_prev_q;
  logic slot_q;
  logic k_rise;
  logic read_cmd;

  // k level one clk back; a rise is seen one clk after it happens
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      k_prev_q <= 1'b0;
    else
      k_prev_q <= k;

  // slot flips on each k rise; the first rise after reset reads
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      slot_q <= SLOT_READ;
    else if (k_rise)
      slot_q <= !slot_q;

  // command values still stand one clk after the k rise
  assign k_rise   = k && !k_prev_q;
  assign read_cmd = k_rise && cmd_valid && !cmd_write;

  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // two words, one half period each, framed by idle phases
  sequence burst_s;
    !read_valid_flag ##1 read_valid_flag [*4] ##1 !read_valid_flag;
  endsequence
  // latency select must have settled well before the read
  sequence long_read_s;
    read_cmd && pll_off_select && $past(pll_off_select, 16);
  endsequence
  sequence short_read_s;
    read_cmd && !pll_off_select && !$past(pll_off_select, 16);
  endsequence

  bus_no_clash_a: assert property (dev_dq_oe_n || ctl_dq_oe_n)
    else $error("both ends drive the data pins");
  valid_marks_drive_a: assert property
    (read_valid_flag == !dev_dq_oe_n)
    else $error("read valid flag differs from device drive");
  echo_follows_k_a: assert property
    (($changed(read_valid_flag) |-> $changed(echo_clock_pair[0])) and
     (echo_clock_pair == {k_n, k}))
    else $error("echo clocks not aligned with link clocks");
  slot_order_a: assert property
    (k_rise && cmd_valid |-> cmd_write == slot_q)
    else $error("command in the wrong address slot");
  write_words_a: assert property
    (k_rise && cmd_valid && cmd_write |->
     !ctl_dq_oe_n [*3] ##1 ctl_dq_oe_n)
    else $error("write words not held across both edges");
  read_gap_a: assert property (read_cmd |=> !cmd_valid [*8])
    else $error("command too soon after a read");
  long_latency_a: assert property (long_read_s |-> ##9 burst_s)
    else $error("read burst not at two and a half cycles");
  short_latency_a: assert property (short_read_s |-> ##3 burst_s)
    else $error("read burst not at one cycle");
endmodule
`default_nettype wire

// ### ddr_link_if.sv
// Purpose: pins between the sram device and the memory controller
// Assumes: the controller makes both link clocks
// Notes:   shared data pins are resolved here from both enables
`timescale 1ns/100ps
`default_nettype none
interface ddr_link_if #(
  parameter int WORD_W = ddr_sram_pkg::DEF_WORD_W,
  parameter int ADDR_W = ddr_sram_pkg::DEF_ADDR_W
);
  logic              k;               // true input clock
  logic              k_n;             // complementary input clock
  logic              cmd_valid;       // address present for this edge
  logic              cmd_write;       // 1 write, 0 read
  logic [ADDR_W-1:0] addr;
  logic [WORD_W-1:0] ctl_dq_out;      // controller drive of data pins
  logic              ctl_dq_oe_n;     // low while controller drives
  logic [WORD_W-1:0] dev_dq_out;      // device drive of data pins
  logic              dev_dq_oe_n;     // low while device drives
  logic [WORD_W-1:0] dq;              // resolved level of data pins
  logic [1:0]        echo_clock_pair; // [0] true, [1] complement
  logic              read_valid_flag;
  logic              pll_off_select;

  // undriven bus reads as zero; both drivers at once is a fault
  assign dq = !dev_dq_oe_n ? dev_dq_out :
              !ctl_dq_oe_n ? ctl_dq_out : '0;

  modport device (
    input  k, k_n, cmd_valid, cmd_write, addr, dq, pll_off_select,
    output dev_dq_out, dev_dq_oe_n, echo_clock_pair, read_valid_flag
  );

  modport controller (
    output k, k_n, cmd_valid, cmd_write, addr, ctl_dq_out,
           ctl_dq_oe_n, pll_off_select,
    input  dq, echo_clock_pair, read_valid_flag
  );
endinterface
`default_nettype wire

// ### ddr_sram_controller.sv
// Purpose: memory controller end of the DDR SRAM link
// Assumes: clk runs at four times the link clock it makes
// Notes:   requests wait in a buffer; one burst per address slot
`timescale 1ns/100ps
`default_nettype none
module req_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = ddr_sram_pkg::REQ_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] buf_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [PTR_W:0]   count_q;
  logic             push;
  logic             pop;

  assign in_ready  = (count_q != (PTR_W+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data  = buf_q[rd_ptr_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage has no reset; only pointers matter
  always_ff @(posedge clk)
  begin
    if (push)
      buf_q[wr_ptr_q] <= in_data;
  end

  // pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      if (pop)
        rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      count_q <= count_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end
endmodule

module ddr_sram_controller #(
  parameter int WORD_W = ddr_sram_pkg::DEF_WORD_W,
  parameter int ADDR_W = ddr_sram_pkg::DEF_ADDR_W
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  ddr_link_if.controller           link,
  input  wire logic                pll_off_level,
  input  wire logic                req_valid,
  output logic                     req_ready,
  input  wire logic                req_write,
  input  wire logic [ADDR_W-1:0]   req_addr,
  input  wire logic [2*WORD_W-1:0] req_wdata,
  output logic                     rsp_valid,
  output logic      [2*WORD_W-1:0] rsp_rdata
);
  import ddr_sram_pkg::*;

  localparam int ENTRY_W = 1 + ADDR_W + 2 * WORD_W;

  logic [1:0]         phase_q;
  logic               k_q;
  logic               kn_q;
  logic               slot_q;
  logic [2:0]         gap_q;
  logic               head_valid;
  logic [ENTRY_W-1:0] head;
  logic               head_write;
  logic               issue;
  logic               cmd_v_q;
  logic               cmd_w_q;
  logic [ADDR_W-1:0]  addr_q;
  logic [WORD_W-1:0]  dq_q;
  logic [WORD_W-1:0]  wd1_q;
  logic               oe_n_q;
  logic               pll_q;
  logic [WORD_W-1:0]  dq_s1_q;
  logic [WORD_W-1:0]  dq_s2_q;
  logic               vld_s1_q;
  logic               vld_s2_q;
  logic               echo_s1_q;
  logic               echo_s2_q;
  logic               echo_s3_q;
  logic [WORD_W-1:0]  lo_q;
  logic               hi_next_q;

  // requests queue here; a full buffer holds off the user
  req_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (REQ_DEPTH)
  ) u_req (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .in_data   ({req_write, req_addr, req_wdata}),
    .out_valid (head_valid),
    .out_ready (issue),
    .out_data  (head)
  );

  assign head_write = head[ENTRY_W-1];

  // link clocks by division; both edges fall on clk edges
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phase_q <= PH_LOW;
      k_q     <= 1'b0;
      kn_q    <= 1'b1;
    end
    else
    begin
      phase_q <= phase_q + 2'h1;
      k_q     <= (phase_q == PH_LOW) || (phase_q == PH_RISE_K);
      kn_q    <= (phase_q == PH_HIGH) || (phase_q == PH_RISE_KN);
    end
  end

  // mirror of the device slot parity, flipped at each k rise
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      slot_q <= SLOT_READ;
    else if (phase_q == PH_LOW)
      slot_q <= ~slot_q;
  end

  // a read owns the data pins for a while; waiting out four k edges
  // keeps a later write clear of it under either latency
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      gap_q <= '0;
    else if (issue && !head_write)
      gap_q <= READ_GAP;
    else if (phase_q == PH_LOW && gap_q != '0)
      gap_q <= gap_q - 3'h1;
  end

  // head-of-line waits at most one edge for its slot
  assign issue = (phase_q == PH_RISE_KN) && head_valid &&
                 (head_write == slot_q) && (gap_q == '0);

  // pins change a quarter period before the edge that samples them
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmd_v_q <= 1'b0;
      cmd_w_q <= 1'b0;
      addr_q  <= '0;
      dq_q    <= '0;
      wd1_q   <= '0;
      oe_n_q  <= 1'b1;
    end
    else if (phase_q == PH_RISE_KN)
    begin
      cmd_v_q <= issue;
      cmd_w_q <= issue && head_write;
      addr_q  <= head[ENTRY_W-2 -: ADDR_W];
      dq_q    <= head[WORD_W-1:0];
      wd1_q   <= head[2*WORD_W-1:WORD_W];
      oe_n_q  <= !(issue && head_write);
    end
    else if (phase_q == PH_RISE_K)
    begin
      cmd_v_q <= 1'b0;
      dq_q    <= wd1_q;
    end
  end

  // static mode pin, registered from the user level
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pll_q <= 1'b1;
    else
      pll_q <= pll_off_level;
  end

  assign link.k              = k_q;
  assign link.k_n            = kn_q;
  assign link.cmd_valid      = cmd_v_q;
  assign link.cmd_write      = cmd_w_q;
  assign link.addr           = addr_q;
  assign link.ctl_dq_out     = dq_q;
  assign link.ctl_dq_oe_n    = oe_n_q;
  assign link.pll_off_select = pll_q;

  // returning pins pass two flops; echo goes the same way so it
  // still lines up with the words
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dq_s1_q   <= '0;
      dq_s2_q   <= '0;
      vld_s1_q  <= 1'b0;
      vld_s2_q  <= 1'b0;
      echo_s1_q <= 1'b0;
      echo_s2_q <= 1'b0;
      echo_s3_q <= 1'b0;
    end
    else
    begin
      dq_s1_q   <= link.dq;
      dq_s2_q   <= dq_s1_q;
      vld_s1_q  <= link.read_valid_flag;
      vld_s2_q  <= vld_s1_q;
      echo_s1_q <= link.echo_clock_pair[0];
      echo_s2_q <= echo_s1_q;
      echo_s3_q <= echo_s2_q;
    end
  end

  // word taken just after each echo edge, only when flagged valid;
  // words pair by arrival order, not echo level, since the long
  // latency puts word 0 on the complement edge
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lo_q      <= '0;
      hi_next_q <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      if (vld_s2_q && (echo_s2_q != echo_s3_q))
      begin
        hi_next_q <= !hi_next_q;
        if (!hi_next_q)
          lo_q <= dq_s2_q;
        else
        begin
          rsp_valid <= 1'b1;
          rsp_rdata <= {dq_s2_q, lo_q};
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### ddr_sram_device.sv
// Purpose: two-word burst DDR SRAM end of the link
// Assumes: k and k_n are complementary, made by the controller
// Notes:   all logic runs on rising edges of k or k_n only
//
// How it works
// - only rising edges of k, k_n used
// - read, write addresses on alternate k edges
// - write words taken on k, then k_n
// - read words launched on k and k_n
// - each address holds a two-word burst
// - pll-off high: read data after 2.5 cycles
// - pll-off low: read data after 1 cycle
// - valid flag marks phases carrying read data
// - echo clocks aligned with read data
// - shared data pins; controller releases during reads
// - inputs and all outputs but echo clocks pass edge registers
// - array write is self-timed internally
`timescale 1ns/100ps
`default_nettype none
module ddr_sram_device #(
  parameter int WORD_W = ddr_sram_pkg::DEF_WORD_W,
  parameter int ADDR_W = ddr_sram_pkg::DEF_ADDR_W
) (
  ddr_link_if.device link,
  input wire logic   reset_n
);
  import ddr_sram_pkg::*;

  localparam int BURST_W = 2 * WORD_W;

  // pll-off pin is static, so it is synchronised into the k domain
  logic [1:0]         pll_sync_q;
  lat_mode_type       lat_mode;

  // k-domain input registers
  logic               slot_q;
  logic               cmd_v_q;
  logic               cmd_w_q;
  logic [ADDR_W-1:0]  addr_q;
  logic [WORD_W-1:0]  wd0_q;

  // k_n-domain input register for the second write word
  logic [WORD_W-1:0]  wd1_q;

  // storage array and read pipeline
  logic [BURST_W-1:0] mem [2**ADDR_W];
  logic [BURST_W-1:0] hold_q;
  logic               rp1_q;
  logic               rp2_q;
  logic               rd_now;
  logic               wr_now;

  // output registers, one set per launching edge
  logic [WORD_W-1:0]  rise_q;
  logic               rise_vld_q;
  logic [WORD_W-1:0]  fall_q;
  logic               fall_vld_q;

  // first flop is read only by the second
  always_ff @(posedge link.k or negedge reset_n)
  begin
    if (!reset_n)
      pll_sync_q <= 2'h0;
    else
      pll_sync_q <= {pll_sync_q[0], link.pll_off_select};
  end

  // low pin falls back to the short legacy latency
  assign lat_mode = pll_sync_q[1] ? LAT_TWO_HALF : LAT_ONE;

  // slot parity: read on even true-clock edges, write on odd
  always_ff @(posedge link.k or negedge reset_n)
  begin
    if (!reset_n)
      slot_q <= SLOT_READ;
    else
      slot_q <= ~slot_q;
  end

  // address, command and first write word taken on k
  always_ff @(posedge link.k or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmd_v_q <= 1'b0;
      cmd_w_q <= 1'b0;
      addr_q  <= '0;
      wd0_q   <= '0;
    end
    else
    begin
      // a command in the wrong slot is ignored
      cmd_v_q <= link.cmd_valid && (link.cmd_write == slot_q);
      cmd_w_q <= link.cmd_write;
      addr_q  <= link.addr;
      wd0_q   <= link.dq;
    end
  end

  // second write word taken on the complementary rising edge
  always_ff @(posedge link.k_n or negedge reset_n)
  begin
    if (!reset_n)
      wd1_q <= '0;
    else
      wd1_q <= link.dq;
  end

  assign rd_now = cmd_v_q && !cmd_w_q;
  assign wr_now = cmd_v_q && cmd_w_q;

  // both words are in place by the next k edge; commit then, so the
  // controller supplies no write pulse of its own
  always_ff @(posedge link.k)
  begin
    if (wr_now)
      mem[addr_q] <= {wd1_q, wd0_q};
  end

  // burst fetched one cycle after the read address
  always_ff @(posedge link.k or negedge reset_n)
  begin
    if (!reset_n)
      hold_q <= '0;
    else if (rd_now)
      hold_q <= mem[addr_q];
  end

  // read pipeline: rp1 true in cycle t+1, rp2 in cycle t+2
  always_ff @(posedge link.k or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rp1_q <= 1'b0;
      rp2_q <= 1'b0;
    end
    else
    begin
      rp1_q <= rd_now;
      rp2_q <= rp1_q;
    end
  end

  // k launches word 0 at t+1 (short) or word 1 at t+3 (long)
  always_ff @(posedge link.k or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rise_q     <= '0;
      rise_vld_q <= 1'b0;
    end
    else if (rd_now && lat_mode == LAT_ONE)
    begin
      rise_q     <= mem[addr_q][WORD_W-1:0];
      rise_vld_q <= 1'b1;
    end
    else if (rp2_q && lat_mode == LAT_TWO_HALF)
    begin
      rise_q     <= hold_q[BURST_W-1:WORD_W];
      rise_vld_q <= 1'b1;
    end
    else
    begin
      rise_q     <= '0;
      rise_vld_q <= 1'b0;
    end
  end

  // k_n launches word 1 at t+1.5 (short) or word 0 at t+2.5 (long)
  always_ff @(posedge link.k_n or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fall_q     <= '0;
      fall_vld_q <= 1'b0;
    end
    else if (rp1_q && lat_mode == LAT_ONE)
    begin
      fall_q     <= hold_q[BURST_W-1:WORD_W];
      fall_vld_q <= 1'b1;
    end
    else if (rp2_q && lat_mode == LAT_TWO_HALF)
    begin
      fall_q     <= hold_q[WORD_W-1:0];
      fall_vld_q <= 1'b1;
    end
    else
    begin
      fall_q     <= '0;
      fall_vld_q <= 1'b0;
    end
  end

  // ddr output cell: the level of k picks the register last launched,
  // so each word stands a full half period on the pins
  assign link.dev_dq_out      = link.k ? rise_q : fall_q;
  assign link.read_valid_flag = link.k ? rise_vld_q : fall_vld_q;
  // pins driven only while a read word is out
  assign link.dev_dq_oe_n     = link.k ? !rise_vld_q : !fall_vld_q;

  // echo edges come from the same edges that launch data, so the
  // controller sees them with the same delay as the words
  assign link.echo_clock_pair = {link.k_n, link.k};

endmodule
`default_nettype wire

// ### ddr_sram_pkg.sv
// Purpose: shared constants of the two-word burst DDR SRAM link
// Assumes: controller clk is four times the link clock
// Notes:   phases count controller clk cycles inside one link period
package ddr_sram_pkg;

  // default geometry: two 18-bit words behind each burst address
  localparam int DEF_WORD_W = 18;
  localparam int DEF_ADDR_W = 20;

  // controller clk cycles per link clock period
  localparam int LINK_DIV = 4;

  // controller phase codes inside one link period
  localparam logic [1:0] PH_RISE_K  = 2'h0; // true clock just rose
  localparam logic [1:0] PH_HIGH    = 2'h1;
  localparam logic [1:0] PH_RISE_KN = 2'h2; // complement just rose
  localparam logic [1:0] PH_LOW     = 2'h3;

  // address slots alternate on true-clock rising edges
  localparam logic SLOT_READ  = 1'h0;
  localparam logic SLOT_WRITE = 1'h1;

  // true-clock edges a read blocks the bus before the next command
  localparam logic [2:0] READ_GAP = 3'h4;

  // depth of the controller request buffer
  localparam int REQ_DEPTH = 8;

  // read return latency selected by the pll-off pin
  typedef enum logic {LAT_ONE, LAT_TWO_HALF} lat_mode_type;

endpackage

// ### testbench.sv
// Purpose: end to end test of controller and sram device
// Assumes: responses return in request order
// Notes:   expected read data kept in a queue, fed by the read task
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ddr_sram_pkg::*;
  localparam int WORD_W = DEF_WORD_W;
  localparam int ADDR_W = DEF_ADDR_W;

  logic                clk;
  logic                reset_n;
  logic                pll_off_level;
  logic                req_valid;
  logic                req_ready;
  logic                req_write;
  logic [ADDR_W-1:0]   req_addr;
  logic [2*WORD_W-1:0] req_wdata;
  logic                rsp_valid;
  logic [2*WORD_W-1:0] rsp_rdata;
  logic [2*WORD_W-1:0] exp_q[$];
  logic [ADDR_W-1:0]   adr[4];
  logic [2*WORD_W-1:0] dat[4];
  logic                full_seen;
  int                  n_fail;
  int                  comparisons;

  ddr_link_if #(.WORD_W(WORD_W), .ADDR_W(ADDR_W)) link ();

  ddr_sram_device #(.WORD_W(WORD_W), .ADDR_W(ADDR_W)) i_ddr_sram_device (
    .link    (link.device),
    .reset_n (reset_n)
  );

  ddr_sram_controller #(.WORD_W(WORD_W), .ADDR_W(ADDR_W))
    i_ddr_sram_controller (
    .clk           (clk),
    .reset_n       (reset_n),
    .link          (link.controller),
    .pll_off_level (pll_off_level),
    .req_valid     (req_valid),
    .req_ready     (req_ready),
    .req_write     (req_write),
    .req_addr      (req_addr),
    .req_wdata     (req_wdata),
    .rsp_valid     (rsp_valid),
    .rsp_rdata     (rsp_rdata)
  );

  ddr_link_assertions i_ddr_link_assertions (
    .clk             (clk),
    .reset_n         (reset_n),
    .k               (link.k),
    .k_n             (link.k_n),
    .cmd_valid       (link.cmd_valid),
    .cmd_write       (link.cmd_write),
    .ctl_dq_oe_n     (link.ctl_dq_oe_n),
    .dev_dq_oe_n     (link.dev_dq_oe_n),
    .echo_clock_pair (link.echo_clock_pair),
    .read_valid_flag (link.read_valid_flag),
    .pll_off_select  (link.pll_off_select)
  );

  // 200 MHz controller clock; the link clock is divided from it
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [2*WORD_W-1:0] seen,
                       input logic [2*WORD_W-1:0] exp, input string msg);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s seen %h want %h", $time, msg,
               seen, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic timeout(input string msg);
    n_fail++;
    $display("CHECK FAILED at %0t: timeout %s", $time, msg);
    results();
  endtask

  // request held until an edge that samples ready high
  task automatic send(input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [2*WORD_W-1:0] d);
    int i;
    i = 0;
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr  <= a;
    req_wdata <= d;
    do
      @(posedge clk);
    while (req_ready !== 1'b1 && ++i < 400);
    if (i >= 400)
      timeout("request not taken");
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a,
                    input logic [2*WORD_W-1:0] d);
    exp_q.push_back(d);
    send(1'b0, a, d);
  endtask

  // release the request, then wait for all reads to come back
  task automatic drain();
    int i;
    req_valid <= 1'b0;
    for (i = 0; i < 2000 && exp_q.size() != 0; i++)
      @(posedge clk);
    if (exp_q.size() != 0)
      timeout("read response missing");
  endtask

  // responses compared in order; an unasked response is an error
  always @(posedge clk)
  begin
    if (req_ready === 1'b0)
      full_seen = 1'b1;
    if (rsp_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(36'h0, 36'h1, "unexpected response");
      else
        check(rsp_rdata, exp_q.pop_front(), "read data");
    end
  end

  initial
  begin
    int i;
    reset_n       = 1'b0;
    pll_off_level = 1'b1;
    req_valid     = 1'b0;
    req_write     = 1'b0;
    req_addr      = '0;
    req_wdata     = '0;
    full_seen     = 1'b0;
    n_fail        = 0;
    comparisons   = 0;
    adr = '{20'h0_0000, 20'hF_FFFF, 20'h5_5555, 20'hA_AAAA};
    dat = '{36'h1_2345_6789, 36'hF_0F0F_0F0F, 36'h0_0003_FFFF,
            36'hA_BCDE_F012};
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    // back-to-back writes at edge addresses, read back at 2.5 latency
    for (i = 0; i < 4; i++)
      send(1'b1, adr[i], dat[i]);
    for (i = 0; i < 4; i++)
      rd(adr[i], dat[i]);
    drain();
    // one cycle latency; overwrite then read the same place at once
    pll_off_level <= 1'b0;
    repeat (40) @(posedge clk);
    send(1'b1, adr[2], ~dat[2]);
    rd(adr[2], ~dat[2]);
    rd(adr[1], dat[1]);
    drain();
    // flood the buffer until it refuses, the link drains it slowly
    for (i = 0; i < 14; i++)
      rd(adr[i % 4], i % 4 == 2 ? ~dat[2] : dat[i % 4]);
    drain();
    check({35'h0, full_seen}, 36'h1, "buffer never full");
    results();
  end
endmodule
`default_nettype wire
